/* File: core/usart_pkg.sv */
// Constants, register map and state codes of the serial port block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`default_nettype none

package usart_pkg;

  //--------------------------------------------------------------------
  // Register offsets
  //--------------------------------------------------------------------
  localparam logic [2:0] A_TXC = 3'h0;
  localparam logic [2:0] A_RXC = 3'h1;
  localparam logic [2:0] A_BDC = 3'h2;
  localparam logic [2:0] A_DLO = 3'h3;
  localparam logic [2:0] A_DHI = 3'h4;
  localparam logic [2:0] A_TXD = 3'h5;
  localparam logic [2:0] A_RXD = 3'h6;
  localparam logic [2:0] A_STAT = 3'h7;

  //--------------------------------------------------------------------
  // Field positions
  //--------------------------------------------------------------------
  localparam int TXC_CLK_SRC = 7;
  localparam int TXC_NINE = 6;
  localparam int TXC_EN = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_BREAK = 3;
  localparam int TXC_HS = 2;
  localparam int TXC_EMPTY = 1;
  localparam int TXC_D9 = 0;
  localparam int RXC_PORT_EN = 7;
  localparam int RXC_NINE = 6;
  localparam int RXC_SINGLE = 5;
  localparam int RXC_CONT = 4;
  localparam int RXC_ADDR = 3;
  localparam int RXC_FRAMING_ERROR = 2;
  localparam int RXC_OVERRUN_ERROR = 1;
  localparam int RXC_D9 = 0;
  localparam int BDC_ROLL = 7;
  localparam int BDC_IDLE = 6;
  localparam int BDC_RXPOL = 5;
  localparam int BDC_TXPOL = 4;
  localparam int BDC_WIDE = 3;
  localparam int BDC_WAKE = 1;
  localparam int BDC_ABD = 0;

  //--------------------------------------------------------------------
  // Reset values and write masks
  //--------------------------------------------------------------------
  localparam logic [7:0] TXC_RESET = 8'h02;
  localparam logic [7:0] RXC_RESET = 8'h00;
  localparam logic [7:0] BDC_RESET = 8'h40;
  localparam logic [7:0] TXC_WMASK = 8'hFD;
  localparam logic [7:0] RXC_WMASK = 8'hF8;
  localparam logic [7:0] BDC_WMASK = 8'hBB;

  //--------------------------------------------------------------------
  // Baud ticks per bit, minus one
  //--------------------------------------------------------------------
  localparam logic [5:0] TPB_LOW_M1 = 6'h3F;
  localparam logic [5:0] TPB_HIGH_M1 = 6'h0F;
  localparam logic [5:0] TPB_FAST_M1 = 6'h03;

  //--------------------------------------------------------------------
  // Frame shapes
  //--------------------------------------------------------------------
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [3:0] FRAME8_LEN = 4'hA;
  localparam logic [3:0] FRAME9_LEN = 4'hB;
  localparam logic [3:0] BREAK_LEN = 4'hE;
  localparam logic [13:0] BREAK_FRAME = 14'h2000;
  localparam logic [2:0] ABD_LAST_EDGE = 3'h4;

  //--------------------------------------------------------------------
  // State codes
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_e;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_SYNC = 5'b01000,
    RX_ABD = 5'b10000
  } rx_state_e;

endpackage : usart_pkg

`default_nettype wire

/* File: core/usart_control_and_baud_gen.sv */
// Serial port control, status, baud generator and line engines
//
// Our own choices: the register offsets and the strobed register port.
`default_nettype none

module usart_control_and_baud_gen (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Transmit / clock pin
  input wire logic i_txclk_pin,
  output logic o_txclk_pin,
  output logic o_txclk_oe_n,
  // Receive / data pin
  input wire logic i_rxdat_pin,
  output logic o_rxdat_pin,
  output logic o_rxdat_oe_n,
  // Status
  output logic o_wake,
  output logic o_rx_full,
  output logic o_tx_empty
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] txc;
    logic [7:0] rxc;
    logic [7:0] bdc;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [15:0] baud_generator;
    logic [7:0] tbuf;
    logic tbuf_full;
    usart_pkg::tx_state_e tst;
    logic [13:0] tsh;
    logic [3:0] tcnt;
    logic [5:0] tsub;
    logic tbrk;
    usart_pkg::rx_state_e rst;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    logic [5:0] rsub;
    logic [1:0] smp;
    logic [7:0] rbuf;
    logic rbuf_full;
    logic line_q;
    logic clk_q;
    logic wk_arm;
    logic [8:0] ab_pre;
    logic [15:0] ab_cnt;
    logic [2:0] ab_edges;
    logic ab_run;
    logic [7:0] rdata;
    logic wake;
    logic txclk_pin;
    logic txclk_oe_n;
    logic rxdat_pin;
    logic rxdat_oe_n;
  } state_s;

  state_s s;
  state_s n;

  //--------------------------------------------------------------------
  // Derived conditions
  //--------------------------------------------------------------------
  logic sync;
  logic master;
  logic pen;
  logic go_sync;
  logic [15:0] div;
  logic [5:0] km1;
  logic [5:0] hm;
  logic [3:0] tbits;
  logic [3:0] rbits;
  logic tick;
  logic line;
  logic fall;
  logic rise;
  logic cidle;
  logic c_trail;
  logic maj;
  logic tadv;
  logic radv;
  logic rdec;
  logic rend;
  logic [8:0] sync_sh;

  assign sync = s.txc[usart_pkg::TXC_SYNC];
  assign master = sync & s.txc[usart_pkg::TXC_CLK_SRC];
  assign pen = s.rxc[usart_pkg::RXC_PORT_EN];
  // Continuous wins over single; single only counts as master
  assign go_sync = s.rxc[usart_pkg::RXC_CONT] |
                   (s.rxc[usart_pkg::RXC_SINGLE] & master);
  assign div = s.bdc[usart_pkg::BDC_WIDE] ? {s.dhi, s.dlo}
                                          : {8'h00, s.dlo};

  always_comb begin
    if (sync) begin
      km1 = usart_pkg::TPB_FAST_M1;
    end else if (s.bdc[usart_pkg::BDC_WIDE] && s.txc[usart_pkg::TXC_HS]) begin
      km1 = usart_pkg::TPB_FAST_M1;
    end else if (s.bdc[usart_pkg::BDC_WIDE] || s.txc[usart_pkg::TXC_HS]) begin
      km1 = usart_pkg::TPB_HIGH_M1;
    end else begin
      km1 = usart_pkg::TPB_LOW_M1;
    end
  end

  assign hm = {1'b0, km1[5:1]};
  assign tbits = s.txc[usart_pkg::TXC_NINE] ? usart_pkg::BITS9
                                            : usart_pkg::BITS8;
  assign rbits = s.rxc[usart_pkg::RXC_NINE] ? usart_pkg::BITS9
                                            : usart_pkg::BITS8;
  // Timer runs free; a tick marks n+1 system clocks
  assign tick = (s.baud_generator >= div);
  assign line = i_rxdat_pin ^ (~sync & s.bdc[usart_pkg::BDC_RXPOL]);
  assign fall = s.line_q & ~line;
  assign rise = ~s.line_q & line;
  assign cidle = s.bdc[usart_pkg::BDC_TXPOL];
  assign c_trail = (s.clk_q != cidle) && (i_txclk_pin == cidle);
  // Two earlier samples plus the live one
  assign maj = (s.smp[0] & s.smp[1]) | (s.smp[0] & line) |
               (s.smp[1] & line);
  assign tadv = sync ? (master ? (tick && s.tsub == 6'h01) : c_trail)
                     : (tick && s.tsub == km1);
  assign radv = master ? (tick && s.rsub == 6'h01) : c_trail;
  assign rdec = tick && (s.rsub == 6'(hm + 6'h02));
  assign rend = tick && (s.rsub == km1);
  assign sync_sh = {i_rxdat_pin, s.rsh[8:1]};

  //--------------------------------------------------------------------
  // Character hand-off to the receive buffer
  //--------------------------------------------------------------------
  function automatic state_s deliver(input state_s st,
                                     input logic [8:0] sh,
                                     input logic stop_ok,
                                     input logic is_sync);
    state_s r;
    logic [7:0] d;
    logic b9;
    r = st;
    d = st.rxc[usart_pkg::RXC_NINE] ? sh[7:0] : sh[8:1];
    b9 = st.rxc[usart_pkg::RXC_NINE] & sh[8];
    if (!is_sync && st.rxc[usart_pkg::RXC_NINE] &&
        st.rxc[usart_pkg::RXC_ADDR] && !b9) begin
      r.rbuf_full = st.rbuf_full;
    end else if (st.rbuf_full) begin
      r.rxc[usart_pkg::RXC_OVERRUN_ERROR] = 1'b1;
    end else begin
      r.rbuf = d;
      r.rxc[usart_pkg::RXC_D9] = b9;
      r.rxc[usart_pkg::RXC_FRAMING_ERROR] = ~stop_ok;
      r.rbuf_full = 1'b1;
    end
    return r;
  endfunction : deliver

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    n = s;
    n.wake = 1'b0;
    n.rdata = 8'h00;
    n.line_q = line;
    n.clk_q = i_txclk_pin;
    n.baud_generator = tick ? 16'h0000 : 16'(s.baud_generator + 16'h0001);

    // Software writes; hardware updates below win over them
    if (i_wr) begin
      case (i_addr)
        usart_pkg::A_TXC: begin
          n.txc = (s.txc & ~usart_pkg::TXC_WMASK) |
                  (i_wdata & usart_pkg::TXC_WMASK);
        end
        usart_pkg::A_RXC: begin
          n.rxc = (s.rxc & ~usart_pkg::RXC_WMASK) |
                  (i_wdata & usart_pkg::RXC_WMASK);
          if (!i_wdata[usart_pkg::RXC_CONT]) begin
            n.rxc[usart_pkg::RXC_OVERRUN_ERROR] = 1'b0;
          end
        end
        usart_pkg::A_BDC: begin
          n.bdc = (s.bdc & ~usart_pkg::BDC_WMASK) |
                  (i_wdata & usart_pkg::BDC_WMASK);
        end
        usart_pkg::A_DLO: begin
          n.dlo = i_wdata;
          n.baud_generator = 16'h0000;
        end
        usart_pkg::A_DHI: begin
          n.dhi = i_wdata;
          n.baud_generator = 16'h0000;
        end
        usart_pkg::A_TXD: begin
          if (!s.tbuf_full) begin
            n.tbuf = i_wdata;
            n.tbuf_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        usart_pkg::A_TXC: n.rdata = s.txc;
        usart_pkg::A_RXC: n.rdata = s.rxc;
        usart_pkg::A_BDC: n.rdata = s.bdc;
        usart_pkg::A_DLO: n.rdata = s.dlo;
        usart_pkg::A_DHI: n.rdata = s.dhi;
        usart_pkg::A_RXD: begin
          n.rdata = s.rbuf;
          n.rbuf_full = 1'b0;
        end
        usart_pkg::A_STAT: n.rdata = {6'h00, s.rbuf_full, s.tbuf_full};
        default: n.rdata = 8'h00;
      endcase
    end

    //------------------------------------------------------------------
    // Transmit engine
    //------------------------------------------------------------------
    case (s.tst)
      usart_pkg::TX_IDLE: begin
        if (pen && s.txc[usart_pkg::TXC_EN] && s.tbuf_full &&
            !(sync && go_sync)) begin
          n.tbuf_full = 1'b0;
          n.tst = usart_pkg::TX_SHIFT;
          n.tsub = 6'h00;
          n.tbrk = 1'b0;
          if (sync) begin
            n.tsh = {5'h00, s.txc[usart_pkg::TXC_D9], s.tbuf};
            n.tcnt = tbits;
          end else if (s.txc[usart_pkg::TXC_BREAK]) begin
            n.tsh = usart_pkg::BREAK_FRAME;
            n.tcnt = usart_pkg::BREAK_LEN;
            n.tbrk = 1'b1;
          end else if (s.txc[usart_pkg::TXC_NINE]) begin
            n.tsh = {4'hF, s.txc[usart_pkg::TXC_D9], s.tbuf, 1'b0};
            n.tcnt = usart_pkg::FRAME9_LEN;
          end else begin
            n.tsh = {5'h1F, s.tbuf, 1'b0};
            n.tcnt = usart_pkg::FRAME8_LEN;
          end
        end
      end
      usart_pkg::TX_SHIFT: begin
        if (tick) begin
          n.tsub = (s.tsub == km1) ? 6'h00 : 6'(s.tsub + 6'h01);
        end
        if (sync && go_sync) begin
          n.tst = usart_pkg::TX_IDLE;
        end else if (tadv) begin
          n.tsh = {1'b1, s.tsh[13:1]};
          n.tcnt = 4'(s.tcnt - 4'h1);
          if (s.tcnt == 4'h1) begin
            n.tst = usart_pkg::TX_IDLE;
            if (s.tbrk) begin
              n.txc[usart_pkg::TXC_BREAK] = 1'b0;
            end
          end
        end
      end
      default: n.tst = usart_pkg::TX_IDLE;
    endcase

    //------------------------------------------------------------------
    // Receive engine
    //------------------------------------------------------------------
    case (s.rst)
      usart_pkg::RX_IDLE: begin
        if (!pen) begin
          n.rst = usart_pkg::RX_IDLE;
        end else if (sync) begin
          if (go_sync) begin
            n.rst = usart_pkg::RX_SYNC;
            n.rsub = 6'h00;
            n.rcnt = rbits;
          end
        end else if (s.bdc[usart_pkg::BDC_ABD]) begin
          // A start edge in the arming cycle still counts
          n.rst = usart_pkg::RX_ABD;
          n.ab_run = fall;
          n.ab_pre = 9'h000;
          n.ab_cnt = 16'h0000;
          n.ab_edges = fall ? 3'h1 : 3'h0;
        end else if (s.bdc[usart_pkg::BDC_WAKE]) begin
          if (fall) begin
            n.wake = 1'b1;
            n.wk_arm = 1'b1;
          end
          if (rise && s.wk_arm) begin
            n.bdc[usart_pkg::BDC_WAKE] = 1'b0;
            n.wk_arm = 1'b0;
          end
        end else if (s.rxc[usart_pkg::RXC_CONT] &&
                     !s.rxc[usart_pkg::RXC_OVERRUN_ERROR] && fall) begin
          n.rst = usart_pkg::RX_START;
          n.rsub = 6'h00;
        end
      end
      usart_pkg::RX_START, usart_pkg::RX_DATA: begin
        if (tick) begin
          n.rsub = (s.rsub == km1) ? 6'h00 : 6'(s.rsub + 6'h01);
          if (s.rsub == hm) begin
            n.smp[0] = line;
          end
          if (s.rsub == 6'(hm + 6'h01)) begin
            n.smp[1] = line;
          end
        end
        if (sync || !s.rxc[usart_pkg::RXC_CONT]) begin
          n.rst = usart_pkg::RX_IDLE;
        end else if (s.rst == usart_pkg::RX_START) begin
          if (rdec && maj) begin
            n.rst = usart_pkg::RX_IDLE;
          end else if (rend) begin
            n.rst = usart_pkg::RX_DATA;
            n.rcnt = rbits;
          end
        end else if (rdec) begin
          if (s.rcnt != 4'h0) begin
            n.rsh = {maj, s.rsh[8:1]};
            n.rcnt = 4'(s.rcnt - 4'h1);
          end else begin
            n = deliver(n, s.rsh, maj, 1'b0);
            n.rst = usart_pkg::RX_IDLE;
          end
        end
      end
      usart_pkg::RX_SYNC: begin
        if (tick) begin
          n.rsub = (s.rsub == km1) ? 6'h00 : 6'(s.rsub + 6'h01);
        end
        if (!sync || !go_sync) begin
          n.rst = usart_pkg::RX_IDLE;
        end else if (radv) begin
          n.rsh = sync_sh;
          n.rcnt = 4'(s.rcnt - 4'h1);
          if (s.rcnt == 4'h1) begin
            n = deliver(n, sync_sh, 1'b1, 1'b1);
            n.rcnt = rbits;
            if (!s.rxc[usart_pkg::RXC_CONT]) begin
              n.rxc[usart_pkg::RXC_SINGLE] = 1'b0;
              n.rst = usart_pkg::RX_IDLE;
            end
          end
        end
      end
      usart_pkg::RX_ABD: begin
        if (sync || !s.bdc[usart_pkg::BDC_ABD]) begin
          n.rst = usart_pkg::RX_IDLE;
        end else begin
          // Counts units of eight times km1+1 system clocks; eight bits span the field
          if (s.ab_run) begin
            if (s.ab_pre == {km1, 3'h7}) begin
              n.ab_pre = 9'h000;
              n.ab_cnt = 16'(s.ab_cnt + 16'h0001);
              if (s.ab_cnt == 16'hFFFF) begin
                n.bdc[usart_pkg::BDC_ROLL] = 1'b1;
              end
            end else begin
              n.ab_pre = 9'(s.ab_pre + 9'h001);
            end
          end
          if (fall) begin
            n.ab_edges = 3'(s.ab_edges + 3'h1);
            n.ab_run = 1'b1;
            if (s.ab_edges == usart_pkg::ABD_LAST_EDGE) begin
              // Unit completing on the last edge is counted
              {n.dhi, n.dlo} = 16'(n.ab_cnt - 16'h0001);
              n.bdc[usart_pkg::BDC_ABD] = 1'b0;
              n.rst = usart_pkg::RX_IDLE;
              n.baud_generator = 16'h0000;
            end
          end
        end
      end
      default: n.rst = usart_pkg::RX_IDLE;
    endcase

    //------------------------------------------------------------------
    // Port disable and status
    //------------------------------------------------------------------
    if (!pen) begin
      n.tst = usart_pkg::TX_IDLE;
      n.rst = usart_pkg::RX_IDLE;
      n.tbuf_full = 1'b0;
      n.rbuf_full = 1'b0;
      n.rxc[usart_pkg::RXC_FRAMING_ERROR] = 1'b0;
      n.rxc[usart_pkg::RXC_OVERRUN_ERROR] = 1'b0;
      n.wk_arm = 1'b0;
    end
    n.txc[usart_pkg::TXC_EMPTY] = (n.tst == usart_pkg::TX_IDLE);
    n.bdc[usart_pkg::BDC_IDLE] = (n.rst == usart_pkg::RX_IDLE);

    //------------------------------------------------------------------
    // Pins
    //------------------------------------------------------------------
    if (!pen) begin
      n.txclk_oe_n = 1'b1;
      n.txclk_pin = 1'b1;
      n.rxdat_oe_n = 1'b1;
      n.rxdat_pin = 1'b1;
    end else if (!sync) begin
      n.txclk_oe_n = 1'b0;
      n.txclk_pin = (n.tst == usart_pkg::TX_SHIFT) ? (n.tsh[0] ^ cidle)
                                                   : ~cidle;
      n.rxdat_oe_n = 1'b1;
      n.rxdat_pin = 1'b1;
    end else begin
      // Clock is active in the first half of each four-tick bit
      n.txclk_oe_n = ~master;
      n.txclk_pin = (((n.tst == usart_pkg::TX_SHIFT) &&
                      (n.tsub[5:1] == 5'h00)) ||
                     ((n.rst == usart_pkg::RX_SYNC) &&
                      (n.rsub[5:1] == 5'h00))) ? ~cidle : cidle;
      n.rxdat_oe_n = ~(n.tst == usart_pkg::TX_SHIFT);
      n.rxdat_pin = n.tsh[0];
    end
  end

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '{txc: usart_pkg::TXC_RESET, rxc: usart_pkg::RXC_RESET,
             bdc: usart_pkg::BDC_RESET, tst: usart_pkg::TX_IDLE,
             rst: usart_pkg::RX_IDLE, line_q: 1'b1, txclk_pin: 1'b1,
             txclk_oe_n: 1'b1, rxdat_pin: 1'b1, rxdat_oe_n: 1'b1,
             tsh: 14'h3FFF, default: '0};
    end else begin
      s <= n;
    end
  end

  assign o_rdata = s.rdata;
  assign o_txclk_pin = s.txclk_pin;
  assign o_txclk_oe_n = s.txclk_oe_n;
  assign o_rxdat_pin = s.rxdat_pin;
  assign o_rxdat_oe_n = s.rxdat_oe_n;
  assign o_wake = s.wake;
  assign o_rx_full = s.rbuf_full;
  assign o_tx_empty = ~s.tbuf_full;

endmodule : usart_control_and_baud_gen

`default_nettype wire

/* File: test/usart_checker.sv */
// Port assertions for the serial port block
`default_nettype none
module usart_checker (
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  // Read strobe, pins and status
  input wire logic i_rd,
  input wire logic o_txclk_pin,
  input wire logic o_txclk_oe_n,
  input wire logic o_rxdat_oe_n,
  input wire logic o_wake,
  input wire logic o_rx_full,
  input wire logic o_tx_empty
);
  logic pen_r, sy_r, ms_r, te_r, tp_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {pen_r, sy_r, ms_r, te_r, tp_r} <= 5'h00;
    end else if (i_wr && i_addr == usart_pkg::A_RXC) begin
      pen_r <= i_wdata[usart_pkg::RXC_PORT_EN];
    end else if (i_wr && i_addr == usart_pkg::A_TXC) begin
      {ms_r, te_r, sy_r} <= {i_wdata[7], i_wdata[5:4]};
    end else if (i_wr && i_addr == usart_pkg::A_BDC) begin
      tp_r <= i_wdata[usart_pkg::BDC_TXPOL];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Async load into an empty transmit buffer
  sequence s_load;
    i_wr && i_addr == usart_pkg::A_TXD && o_tx_empty && pen_r && te_r
      && !sy_r;
  endsequence
  // Pin enables are registered, so config must stand one cycle
  a_port_off_release: assert property (!pen_r && !$past(pen_r) |->
    o_txclk_oe_n && o_rxdat_oe_n) else $error("pins driven while off");
  a_load_fills: assert property (s_load |=> !o_tx_empty)
    else $error("load not taken");
  a_start_bit: assert property (s_load |-> ##[1:4] o_txclk_pin == tp_r)
    else $error("start bit missing");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake pulse too long");
  a_read_drains: assert property (
    i_rd && i_addr == usart_pkg::A_RXD |=> !o_rx_full)
    else $error("buffer still full");
  a_master_drives: assert property (pen_r && sy_r && ms_r &&
    $past(pen_r && sy_r && ms_r) |-> !o_txclk_oe_n)
    else $error("master clock released");
  a_slave_listens: assert property (pen_r && sy_r && !ms_r &&
    $past(pen_r && sy_r && !ms_r) |-> o_txclk_oe_n)
    else $error("slave drives clock");
  a_async_data_in: assert property (pen_r && !sy_r &&
    $past(pen_r && !sy_r) |-> o_rxdat_oe_n) else $error("rx pin driven");
endmodule : usart_checker
`default_nettype wire

/* File: test/serial_peer.sv */
// Remote asynchronous station on the serial lines
`default_nettype none
module serial_peer (
  // Clock and bit length in system clocks
  input wire logic i_clk,
  input var int i_bit_cyc,
  // Lines
  input wire logic i_line,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_line = 1'b1;
  // Start, eight data bits LSB first, one stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_line <= f[i];
      repeat (i_bit_cyc) @(posedge i_clk);
    end
  endtask : send
  // Mid-bit sampling; returns after the stop bit is over
  task automatic recv(output logic [7:0] d);
    while (i_line !== 1'b0) @(posedge i_clk);
    repeat (i_bit_cyc / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (i_bit_cyc) @(posedge i_clk);
      d[i] = i_line;
    end
    repeat (i_bit_cyc * 2) @(posedge i_clk);
  endtask : recv
endmodule : serial_peer
`default_nettype wire

/* File: test/testbench.sv */
// Register-level tests of the serial port block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, b;
  logic o_txclk_pin, o_txclk_oe_n, o_rxdat_pin, o_rxdat_oe_n;
  logic o_wake, o_rx_full, o_tx_empty, peer_line, tx_w, rx_w;
  logic woke = 1'b0;
  int bit_cyc = 64;
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] txc_v [3] = '{8'h20, 8'h24, 8'h24};
  logic [7:0] bdc_v [3] = '{8'h00, 8'h00, 8'h08};
  logic [7:0] dlo_v [3] = '{8'h00, 8'h01, 8'h02};
  logic [7:0] dat_v [3] = '{8'hA5, 8'h3C, 8'h5A};
  int per_v [3] = '{64, 32, 1036};
  // A released clock pin floats to the pull-up level; a released data pin follows the peer
  assign tx_w = o_txclk_oe_n ? 1'b1 : o_txclk_pin;
  assign rx_w = o_rxdat_oe_n ? peer_line : o_rxdat_pin;
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_wake === 1'b1) woke <= 1'b1;
  usart_control_and_baud_gen u_usart_control_and_baud_gen (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_txclk_pin(tx_w),
    .o_txclk_pin(o_txclk_pin), .o_txclk_oe_n(o_txclk_oe_n),
    .i_rxdat_pin(rx_w), .o_rxdat_pin(o_rxdat_pin),
    .o_rxdat_oe_n(o_rxdat_oe_n), .o_wake(o_wake), .o_rx_full(o_rx_full),
    .o_tx_empty(o_tx_empty));
  serial_peer u_serial_peer (.i_clk(i_clk), .i_bit_cyc(bit_cyc),
    .i_line(tx_w), .o_line(peer_line));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask : rc
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rc(usart_pkg::A_TXC, 8'h02);
    rc(usart_pkg::A_RXC, 8'h00);
    rc(usart_pkg::A_BDC, 8'h40);
    wr(usart_pkg::A_TXC, 8'hF5);
    rc(usart_pkg::A_TXC, 8'hF7);
    wr(usart_pkg::A_BDC, 8'h38);
    rc(usart_pkg::A_BDC, 8'h78);
    $display("registers done");
    wr(usart_pkg::A_RXC, 8'h80);
    wr(usart_pkg::A_TXC, 8'h90);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_txclk_oe_n}, 8'h00);
    wr(usart_pkg::A_TXC, 8'h10);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_txclk_oe_n}, 8'h01);
    wr(usart_pkg::A_RXC, 8'h00);
    $display("sync pins done");
    // High byte only counts in the last, wide setting
    wr(usart_pkg::A_DHI, 8'h01);
    for (int i = 0; i < 3; i++) begin
      bit_cyc = per_v[i];
      wr(usart_pkg::A_TXC, txc_v[i]);
      wr(usart_pkg::A_BDC, bdc_v[i]);
      wr(usart_pkg::A_DLO, dlo_v[i]);
      wr(usart_pkg::A_RXC, 8'h90);
      fork
        u_serial_peer.recv(b);
        wr(usart_pkg::A_TXD, dat_v[i]);
      join
      chk(b, dat_v[i]);
      u_serial_peer.send(~dat_v[i]);
      for (int k = 0; k < 99 && o_rx_full !== 1'b1; k++) @(posedge i_clk);
      rc(usart_pkg::A_RXD, ~dat_v[i]);
      $display("rate %0d done", i);
    end
    bit_cyc = 32;
    wr(usart_pkg::A_BDC, 8'h00);
    wr(usart_pkg::A_DLO, 8'h01);
    wr(usart_pkg::A_TXC, 8'h2C);
    wr(usart_pkg::A_TXD, 8'h00);
    repeat (700) @(posedge i_clk);
    rc(usart_pkg::A_TXC, 8'h26);
    u_serial_peer.send(8'h11);
    u_serial_peer.send(8'h22);
    rc(usart_pkg::A_RXC, 8'h92);
    wr(usart_pkg::A_RXC, 8'h80);
    wr(usart_pkg::A_RXC, 8'h90);
    rc(usart_pkg::A_RXC, 8'h90);
    rc(usart_pkg::A_RXD, 8'h11);
    $display("break and overrun done");
    wr(usart_pkg::A_BDC, 8'h02);
    u_serial_peer.send(8'h00);
    rc(usart_pkg::A_BDC, 8'h40);
    chk({7'h00, woke}, 8'h01);
    $display("wake done");
    wr(usart_pkg::A_DLO, 8'h07);
    wr(usart_pkg::A_BDC, 8'h01);
    u_serial_peer.send(8'h55);
    rc(usart_pkg::A_BDC, 8'h40);
    rc(usart_pkg::A_DLO, 8'h01);
    rc(usart_pkg::A_DHI, 8'h00);
    $display("auto-baud done");
    test_done();
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    test_done();
  end
endmodule : testbench
bind usart_control_and_baud_gen usart_checker u_usart_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_txclk_pin(o_txclk_pin),
  .o_txclk_oe_n(o_txclk_oe_n), .o_rxdat_oe_n(o_rxdat_oe_n),
  .o_wake(o_wake), .o_rx_full(o_rx_full), .o_tx_empty(o_tx_empty));
`default_nettype wire
